// file: core/timer_capture_match_unit.sv
// Timer with prescaler, four snapshot channels and four compare channels,
// reached as a classic Wishbone slave.
// Assumes one clock ref_clk that serves both as bus clock and timer branch clock.
//
// Functional notes
// - Prescale counter terminal count advances 32-bit timer counter by one.
// - Prescale limit is programmable over full 32 bits; rate is clock over limit, or clock itself for limit 0.
// - Both counters run on the timer clock; time is counted in its periods.
// - Any change on a snapshot input copies the timer count into its register.
// - Snapshot raises an event flag only when that channel enables it.
// - Four 32-bit compare registers; equality detected; count may keep running.
// - Stop-on-match halts the timer counter, optionally flagging an event.
// - Restart-on-match returns the timer counter to zero, optionally flagging.
// - Each compare channel drives an output pin: low, high, toggle or keep.
// - Snapshot channels 0..3 are inputs, compare channels 0..3 are outputs.
// - Optional pause input suspends counting while the outside source holds it.
// - Register side and counters share one clock of identical frequency.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_cfg.svh"

module timer_capture_match_unit #(
	parameter bit PAUSE_PRESENT = 1'b0
) (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	// Wishbone slave
	input  wire tcm_pkg::wb_req_t             wb_req,
	output tcm_pkg::wb_rsp_t                  wb_rsp,
	// Timer pins
	input  wire logic [`TCM_CHANNELS-1:0]     snapshot_input,
	input  wire logic                         pause_in,
	output logic      [`TCM_CHANNELS-1:0]     compare_output,
	// Combined event level
	output logic                              irq
);

	localparam int NCH = `TCM_CHANNELS;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	function automatic logic [31:0] byte_merge(
		input logic [31:0] old_v,
		input logic [31:0] wdat,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic adr_is(
		input logic [`TCM_ADR_W-1:0] adr,
		input logic [`TCM_ADR_W-1:0] ofs
	);
		return adr[`TCM_ADR_W-1:2] == ofs[`TCM_ADR_W-1:2];
	endfunction

	function automatic logic [`TCM_ADR_W-1:0] word_ofs(
		input logic [`TCM_ADR_W-1:0] base,
		input int                    idx
	);
		return base + `TCM_ADR_W'(idx * 4);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------

	tcm_pkg::wb_rsp_t             rsp_q;
	logic                         run_q;
	logic                         hold_clear_q;
	logic [31:0]                  count_q;
	logic [31:0]                  pre_limit_q;
	tcm_pkg::match_mode_t         mode_q   [NCH];
	logic [NCH-1:0]               snap_irq_en_q;
	tcm_pkg::pin_action_t         action_q [NCH];
	logic [NCH-1:0]               pin_q;
	logic [2*NCH-1:0]             flags_q;
	logic                         irq_q;
	logic [31:0]                  compare_q  [NCH];
	logic [31:0]                  snapshot_q [NCH];

	logic                         take;
	logic                         wr;
	logic [31:0]                  rd_data;
	logic [NCH:0]                 sync_level;
	logic [NCH:0]                 sync_change;
	logic [NCH-1:0]               snap_event;
	logic                         paused;
	logic                         counting;
	logic                         tick;
	logic [31:0]                  pre_count;
	logic [NCH-1:0]               hit;
	logic                         any_restart;
	logic                         any_stop;
	logic [2*NCH-1:0]             flags_set;
	logic [2*NCH-1:0]             flags_clr;
	logic [2*NCH-1:0]             flags_d;

	// ------------------------------------------------------------------
	// Pin synchronisation and prescaler
	// ------------------------------------------------------------------

	// The pause pin rides in the same synchroniser as the snapshot pins
	snapshot_sync #(
		.WIDTH (NCH + 1)
	) u_sync (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.raw_in     ({pause_in, snapshot_input}),
		.level_out  (sync_level),
		.change_out (sync_change)
	);

	assign snap_event = sync_change[NCH-1:0];
	// A timer variant with pins has no pause; the parameter removes it
	assign paused     = PAUSE_PRESENT && sync_level[NCH];
	assign counting   = run_q && !hold_clear_q && !paused;

	prescale_divider u_pre (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (counting),
		.clear   (hold_clear_q),
		.limit   (pre_limit_q),
		.tick    (tick),
		.count   (pre_count)
	);

	// ------------------------------------------------------------------
	// Compare detection
	// ------------------------------------------------------------------

	// Equality is judged on the advancing tick only, so a held count cannot
	// fire its channel again on every clock of a slow prescale period.
	always_comb begin
		hit         = '0;
		any_restart = 1'b0;
		any_stop    = 1'b0;
		for (int n = 0; n < NCH; n++) begin
			hit[n] = tick && (count_q == compare_q[n]);
			if (hit[n] && mode_q[n].restart) begin
				any_restart = 1'b1;
			end
			if (hit[n] && mode_q[n].stop) begin
				any_stop = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------

	assign take = wb_req.cyc && wb_req.stb && !rsp_q.ack;
	assign wr   = take && wb_req.we;

	always_comb begin
		rd_data = 32'h0000_0000;
		if (adr_is(wb_req.adr, `TCM_OFS_RUN_CTRL)) begin
			rd_data[`TCM_RUN_ENABLE_BIT] = run_q;
			rd_data[`TCM_RUN_CLEAR_BIT]  = hold_clear_q;
		end
		if (adr_is(wb_req.adr, `TCM_OFS_COUNT)) begin
			rd_data = count_q;
		end
		if (adr_is(wb_req.adr, `TCM_OFS_PRE_LIMIT)) begin
			rd_data = pre_limit_q;
		end
		if (adr_is(wb_req.adr, `TCM_OFS_PRE_VALUE)) begin
			rd_data = pre_count;
		end
		if (adr_is(wb_req.adr, `TCM_OFS_SNAP_CTRL)) begin
			rd_data[NCH-1:0] = snap_irq_en_q;
		end
		if (adr_is(wb_req.adr, `TCM_OFS_EVENT_FLAGS)) begin
			rd_data[2*NCH-1:0] = flags_q;
		end
		for (int n = 0; n < NCH; n++) begin
			if (adr_is(wb_req.adr, `TCM_OFS_MATCH_CTRL)) begin
				rd_data[`TCM_MCTRL_STRIDE*n +: `TCM_MCTRL_STRIDE] = mode_q[n];
			end
			if (adr_is(wb_req.adr, `TCM_OFS_PIN_CTRL)) begin
				rd_data[n]                            = pin_q[n];
				rd_data[`TCM_PIN_ACT_BASE + 2*n +: 2] = action_q[n];
			end
			if (adr_is(wb_req.adr, word_ofs(`TCM_OFS_COMPARE0, n))) begin
				rd_data = compare_q[n];
			end
			if (adr_is(wb_req.adr, word_ofs(`TCM_OFS_SNAPSHOT0, n))) begin
				rd_data = snapshot_q[n];
			end
		end
	end

	// Ack one clock after the request; unmapped words read as zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rsp_q <= '0;
		end else begin
			rsp_q.ack <= take;
			if (take) begin
				rsp_q.dat <= wb_req.we ? 32'h0000_0000 : rd_data;
			end
		end
	end

	// ------------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------------

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_q        <= 1'b0;
			hold_clear_q <= 1'b0;
		end else if (wr && adr_is(wb_req.adr, `TCM_OFS_RUN_CTRL) && wb_req.sel[0]) begin
			run_q        <= wb_req.dat[`TCM_RUN_ENABLE_BIT];
			hold_clear_q <= wb_req.dat[`TCM_RUN_CLEAR_BIT];
		end else if (any_stop) begin
			run_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pre_limit_q <= `TCM_RST_PRE_LIMIT;
		end else if (wr && adr_is(wb_req.adr, `TCM_OFS_PRE_LIMIT)) begin
			pre_limit_q <= byte_merge(pre_limit_q, wb_req.dat, wb_req.sel);
		end
	end

	// ------------------------------------------------------------------
	// Timer counter
	// ------------------------------------------------------------------

	// A software write beats the tick that lands in the same clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_q <= `TCM_RST_WORD;
		end else if (wr && adr_is(wb_req.adr, `TCM_OFS_COUNT)) begin
			count_q <= byte_merge(count_q, wb_req.dat, wb_req.sel);
		end else if (hold_clear_q) begin
			count_q <= 32'h0000_0000;
		end else if (tick) begin
			if (any_restart) begin
				count_q <= 32'h0000_0000;
			end else if (any_stop) begin
				count_q <= count_q;
			end else begin
				count_q <= count_q + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Compare channels: values, modes, output pins
	// ------------------------------------------------------------------

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int n = 0; n < NCH; n++) begin
				compare_q[n] <= `TCM_RST_WORD;
				mode_q[n]    <= '0;
			end
		end else if (wr) begin
			for (int n = 0; n < NCH; n++) begin
				if (adr_is(wb_req.adr, word_ofs(`TCM_OFS_COMPARE0, n))) begin
					compare_q[n] <= byte_merge(compare_q[n], wb_req.dat, wb_req.sel);
				end
				if (adr_is(wb_req.adr, `TCM_OFS_MATCH_CTRL) && wb_req.sel[0] && wb_req.sel[1]) begin
					mode_q[n] <= wb_req.dat[`TCM_MCTRL_STRIDE*n +: `TCM_MCTRL_STRIDE];
				end
			end
		end
	end

	// A hit with action low, high or toggle overrides a software write of the same pin in the same clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_q <= '0;
			for (int n = 0; n < NCH; n++) begin
				action_q[n] <= tcm_pkg::PIN_KEEP;
			end
		end else begin
			for (int n = 0; n < NCH; n++) begin
				if (wr && adr_is(wb_req.adr, `TCM_OFS_PIN_CTRL) && wb_req.sel[0]) begin
					pin_q[n]    <= wb_req.dat[n];
					action_q[n] <= tcm_pkg::pin_action_t'(wb_req.dat[`TCM_PIN_ACT_BASE + 2*n +: 2]);
				end
				if (hit[n]) begin
					case (action_q[n])
						tcm_pkg::PIN_LOW: begin
							pin_q[n] <= 1'b0;
						end
						tcm_pkg::PIN_HIGH: begin
							pin_q[n] <= 1'b1;
						end
						tcm_pkg::PIN_TOGGLE: begin
							pin_q[n] <= !pin_q[n];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	assign compare_output = pin_q;

	// ------------------------------------------------------------------
	// Snapshot channels
	// ------------------------------------------------------------------

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			snap_irq_en_q <= '0;
		end else if (wr && adr_is(wb_req.adr, `TCM_OFS_SNAP_CTRL) && wb_req.sel[0]) begin
			snap_irq_en_q <= wb_req.dat[NCH-1:0];
		end
	end

	// Capture happens even while the counter is stopped or paused
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int n = 0; n < NCH; n++) begin
				snapshot_q[n] <= `TCM_RST_WORD;
			end
		end else begin
			for (int n = 0; n < NCH; n++) begin
				if (snap_event[n]) begin
					snapshot_q[n] <= count_q;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Event flags: write one to clear, a new event wins over its clear
	// ------------------------------------------------------------------

	always_comb begin
		flags_set = '0;
		for (int n = 0; n < NCH; n++) begin
			flags_set[n]                          = hit[n] && mode_q[n].irq_en;
			flags_set[`TCM_FLAG_SNAP_BASE + n]    = snap_event[n] && snap_irq_en_q[n];
		end
		flags_clr = '0;
		if (wr && adr_is(wb_req.adr, `TCM_OFS_EVENT_FLAGS) && wb_req.sel[0]) begin
			flags_clr = wb_req.dat[2*NCH-1:0];
		end
		flags_d = (flags_q & ~flags_clr) | flags_set;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flags_q <= '0;
			irq_q   <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq_q   <= |flags_d;
		end
	end

	assign irq    = irq_q;
	assign wb_rsp = rsp_q;

endmodule

`default_nettype wire

// file: shared/tcm_cfg.svh
// Constants of the timer with capture and match channels: register offsets,
// field positions, reset values and clock figures.
// Assumes it is included by bare name wherever a number of the block is needed.
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

`define TCM_CHANNELS        4
`define TCM_ADR_W           8
`define TCM_CLK_HZ          25000000
`define TCM_CLK_PERIOD_NS   40

// Register byte offsets, one aligned 32-bit word each
`define TCM_OFS_RUN_CTRL     8'h00
`define TCM_OFS_COUNT        8'h04
`define TCM_OFS_PRE_LIMIT    8'h08
`define TCM_OFS_PRE_VALUE    8'h0C
`define TCM_OFS_MATCH_CTRL   8'h10
`define TCM_OFS_SNAP_CTRL    8'h14
`define TCM_OFS_PIN_CTRL     8'h18
`define TCM_OFS_EVENT_FLAGS  8'h1C
`define TCM_OFS_COMPARE0     8'h20
`define TCM_OFS_SNAPSHOT0    8'h30

// Field positions
`define TCM_RUN_ENABLE_BIT   0
`define TCM_RUN_CLEAR_BIT    1
`define TCM_MCTRL_STRIDE     3
`define TCM_PIN_ACT_BASE     4
`define TCM_FLAG_SNAP_BASE   4

// Reset values
`define TCM_RST_WORD         32'h0000_0000
`define TCM_RST_PRE_LIMIT    32'h0000_0000

`endif

// file: shared/tcm_pkg.sv
// Types shared by the timer block: bus carriers, match modes, pin actions.
// Assumes tcm_cfg.svh is on the include path.
`include "tcm_cfg.svh"

package tcm_pkg;

	typedef struct packed {
		logic                     cyc;
		logic                     stb;
		logic                     we;
		logic [`TCM_ADR_W-1:0]    adr;
		logic [3:0]               sel;
		logic [31:0]              dat;
	} wb_req_t;

	typedef struct packed {
		logic                     ack;
		logic [31:0]              dat;
	} wb_rsp_t;

	// Field order matches bit order inside one match control slice
	typedef struct packed {
		logic                     stop;
		logic                     restart;
		logic                     irq_en;
	} match_mode_t;

	typedef enum logic [1:0] {
		PIN_KEEP,
		PIN_LOW,
		PIN_HIGH,
		PIN_TOGGLE
	} pin_action_t;

endpackage

// file: core/snapshot_sync.sv
// Two-flop synchroniser with change detection for a group of pin inputs.
// Assumes the inputs are asynchronous to ref_clk and held for at least two periods.
`timescale 1ns/1ns
`default_nettype none

module snapshot_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Raw pins
	input  wire logic [WIDTH-1:0] raw_in,
	// Synchronised level and one-cycle change pulse
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] change_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] prev_q;

	// Only stable_q reads meta_q
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q   <= '0;
			stable_q <= '0;
			prev_q   <= '0;
		end else begin
			meta_q   <= raw_in;
			stable_q <= meta_q;
			prev_q   <= stable_q;
		end
	end

	assign level_out  = stable_q;
	assign change_out = stable_q ^ prev_q;

endmodule

`default_nettype wire

// file: core/prescale_divider.sv
// Prescale counter: counts timer clocks and gives one tick per prescale period.
// Assumes limit is steady while run is high; a limit of 0 or 1 ticks every clock.
`timescale 1ns/1ns
`default_nettype none

module prescale_divider (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        run,
	input  wire logic        clear,
	input  wire logic [31:0] limit,
	// Result
	output logic             tick,
	output logic      [31:0] count
);

	logic [31:0] count_q;
	logic        last;

	assign last  = (limit <= 32'h0000_0001) || (count_q >= limit - 32'h0000_0001);
	assign tick  = run && last && !clear;
	assign count = count_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_q <= 32'h0000_0000;
		end else if (clear) begin
			count_q <= 32'h0000_0000;
		end else if (run) begin
			if (last) begin
				count_q <= 32'h0000_0000;
			end else begin
				count_q <= count_q + 32'h0000_0001;
			end
		end
	end

endmodule

`default_nettype wire

// file: testbench/tcm_chk.sv
// Port-level checks of the timer block: bus handshake, read data and event level.
// Assumes one clock ref_clk and synchronous active-low rst_n.
`timescale 1ns/1ns
`default_nettype none

module tcm_chk (
	// Clock and reset
	input wire logic             ref_clk,
	input wire logic             rst_n,
	// Bus
	input wire tcm_pkg::wb_req_t wb_req,
	input wire tcm_pkg::wb_rsp_t wb_rsp,
	// Pins and event level
	input wire logic [3:0]       snapshot_input,
	input wire logic             pause_in,
	input wire logic [3:0]       compare_output,
	input wire logic             irq
);
	logic flag_wr;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Acked write to the event flag word, the only way to clear a flag
	assign flag_wr = wb_rsp.ack && wb_req.we && wb_req.adr[7:2] == 6'h07;

	sequence taken_s;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	endsequence

	sequence answer_s;
		taken_s ##1 wb_rsp.ack;
	endsequence

	AST_ACK_ANSWER: assert property (taken_s |=> wb_rsp.ack)
		else $error("request not answered in one cycle");
	AST_ACK_PULSE: assert property (answer_s |=> !wb_rsp.ack)
		else $error("ack held beyond one cycle");
	AST_ACK_CAUSE: assert property (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without request");
	AST_WRITE_ZERO: assert property (wb_rsp.ack && $past(wb_req.we) |-> wb_rsp.dat == 32'h0)
		else $error("write answered with nonzero data");
	AST_UNMAPPED: assert property (wb_rsp.ack && $past(!wb_req.we && wb_req.adr >= 8'h40) |-> wb_rsp.dat == 32'h0)
		else $error("unmapped read returned data");
	AST_DAT_HOLD: assert property (!(wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> $stable(wb_rsp.dat))
		else $error("read data changed without request");
	// The clear lands at the taking edge, so the level is seen low while its ack still stands
	AST_IRQ_CLEAR: assert property ($fell(irq) |-> flag_wr)
		else $error("event level fell without a flag clear");
	AST_RESET_QUIET: assert property ($rose(rst_n) |-> !irq && !wb_rsp.ack && compare_output == 4'h0)
		else $error("outputs not quiet after reset");
endmodule

`default_nettype wire

// file: testbench/pin_partner.sv
// Far-side pin model: toggles snapshot pins and holds the pause level.
// Assumes flip requests are one-cycle pulses on the timer clock; hold_req is a held level.
`timescale 1ns/1ns
`default_nettype none

module pin_partner (
	// Clock
	input  wire logic       ref_clk,
	// Requests from the bench
	input  wire logic [3:0] flip,
	input  wire logic       hold_req,
	// Pins toward the timer
	output logic      [3:0] snapshot_input,
	output logic            pause_in
);
	initial begin
		snapshot_input = 4'h0;
		pause_in = 1'b0;
	end

	// Each transition is held until the next request, far longer than the synchroniser needs
	always @(posedge ref_clk) begin
		snapshot_input <= snapshot_input ^ flip;
		pause_in <= hold_req;
	end
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench of the timer: registers, stop, restart, pins, snapshots, pause.
// Assumes the design package, the checker and the pin partner are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_cfg.svh"

module tb_top;
	logic             ref_clk;
	logic             rst_n;
	tcm_pkg::wb_req_t wb_req;
	tcm_pkg::wb_rsp_t wb_rsp;
	logic [3:0]       snapshot_input;
	logic             pause_in;
	logic [3:0]       compare_output;
	logic             irq;
	logic [3:0]       flip;
	logic             hold_req;
	logic [31:0]      q;
	logic [31:0]      l_val;
	logic [31:0]      m_val;
	logic [31:0]      k_val;
	logic [3:0]       lv;
	integer           mismatches;
	integer           checks_done;
	integer           seed;
	integer           n;
	integer           d;

	timer_capture_match_unit #(.PAUSE_PRESENT(1'b1)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.snapshot_input(snapshot_input), .pause_in(pause_in),
		.compare_output(compare_output), .irq(irq));
	pin_partner partner (.ref_clk(ref_clk), .flip(flip), .hold_req(hold_req),
		.snapshot_input(snapshot_input), .pause_in(pause_in));

	always #(`TCM_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] r);
		int t;
		t = 0;
		@(posedge ref_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: dv};
		do begin
			@(posedge ref_clk);
			t++;
		end while (wb_rsp.ack !== 1'b1 && t < 50);
		if (t >= 50) chk(32'h0, 32'h1, "bus answer");
		r = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		logic [31:0] r;
		bus(1'b1, a, dv, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	task automatic ticks(input int c);
		repeat (c) @(posedge ref_clk);
	endtask

	// Channel n uses action n: keep, low, high, toggle
	function automatic logic [3:0] pins_after(input logic [3:0] v);
		return {~v[3], 1'b1, 1'b0, v[0]};
	endfunction

	// Cycles from the end of the run write until the event level is seen high
	function automatic int stop_delay(input int l, input int m);
		return (m + 1) * ((l < 2) ? 1 : l) + 1;
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		wb_req = '0;
		flip = 4'h0;
		hold_req = 1'b0;
		mismatches = 0;
		checks_done = 0;
		seed = 32'hE2A8F7F0;
		ticks(16);
		rst_n <= 1'b1;
		rd(`TCM_OFS_PRE_LIMIT, q);
		chk(q, `TCM_RST_PRE_LIMIT, "limit reset");
		rd(`TCM_OFS_RUN_CTRL, q);
		chk(q, `TCM_RST_WORD, "run reset");
		k_val = $random(seed);
		wr(`TCM_OFS_PRE_LIMIT, k_val);
		rd(`TCM_OFS_PRE_LIMIT, q);
		chk(q, k_val, "limit width");
		for (int c = 0; c < 4; c++) begin
			wr(`TCM_OFS_COMPARE0 + 8'(4 * c), k_val ^ c);
			rd(`TCM_OFS_COMPARE0 + 8'(4 * c), q);
			chk(q, k_val ^ c, "compare word");
		end
		wr(8'h40, k_val);
		rd(8'h40, q);
		chk(q, 32'h0, "unmapped");
		$display("test registers done");
		// Stop on match with every pin action, prescale rate measured
		for (int i = 0; i < 3; i++) begin
			l_val = (i == 0) ? 32'h1 : 32'h2 + $unsigned($random(seed)) % 3;
			m_val = 32'h4 + $unsigned($random(seed)) % 17;
			lv = 4'($random(seed));
			for (int c = 0; c < 4; c++) wr(`TCM_OFS_COMPARE0 + 8'(4 * c), m_val);
			wr(`TCM_OFS_MATCH_CTRL, 32'h0000_0A00);
			wr(`TCM_OFS_PIN_CTRL, {20'h0, 8'hE4, lv});
			chk(32'(compare_output), 32'(lv), "pin level");
			wr(`TCM_OFS_RUN_CTRL, 32'h2);
			wr(`TCM_OFS_PRE_LIMIT, l_val);
			wr(`TCM_OFS_RUN_CTRL, 32'h1);
			d = stop_delay(l_val, m_val);
			n = 0;
			while (irq !== 1'b1 && n < 2000) begin
				@(posedge ref_clk);
				n++;
			end
			chk(32'(n >= d - 2 && n <= d + 2), 32'h1, "stop timing");
			rd(`TCM_OFS_COUNT, q);
			chk(q, m_val, "stopped count");
			rd(`TCM_OFS_RUN_CTRL, q);
			chk(q, 32'h0, "run cleared");
			chk(32'(compare_output), 32'(pins_after(lv)), "pin action");
			rd(`TCM_OFS_EVENT_FLAGS, q);
			chk(q, 32'h8, "match flags");
			wr(`TCM_OFS_EVENT_FLAGS, 32'hFF);
			ticks(2);
			chk(32'(irq), 32'h0, "flags cleared");
		end
		$display("test stop done");
		// Restart on match keeps the count inside 0..m
		l_val = 32'h3;
		m_val = 32'h5 + $unsigned($random(seed)) % 10;
		wr(`TCM_OFS_RUN_CTRL, 32'h2);
		wr(`TCM_OFS_PRE_LIMIT, l_val);
		wr(`TCM_OFS_COMPARE0, m_val);
		wr(`TCM_OFS_MATCH_CTRL, 32'h3);
		wr(`TCM_OFS_RUN_CTRL, 32'h1);
		for (int i = 0; i < 12; i++) begin
			ticks($unsigned($random(seed)) % 23);
			rd(`TCM_OFS_COUNT, q);
			chk(32'(q <= m_val), 32'h1, "restart range");
			rd(`TCM_OFS_PRE_VALUE, q);
			chk(32'(q < l_val), 32'h1, "prescale range");
		end
		chk(32'(irq), 32'h1, "restart event");
		wr(`TCM_OFS_RUN_CTRL, 32'h0);
		wr(`TCM_OFS_EVENT_FLAGS, 32'hFF);
		$display("test restart done");
		// Snapshots on each pin, with and without events
		wr(`TCM_OFS_MATCH_CTRL, 32'h0);
		lv = 4'($random(seed));
		wr(`TCM_OFS_SNAP_CTRL, {28'h0, lv});
		for (int c = 0; c < 4; c++) begin
			k_val = $random(seed);
			wr(`TCM_OFS_COUNT, k_val);
			flip <= 4'(1 << c);
			@(posedge ref_clk);
			flip <= 4'h0;
			ticks(8);
			rd(`TCM_OFS_SNAPSHOT0 + 8'(4 * c), q);
			chk(q, k_val, "snapshot");
			chk(32'(irq), 32'(lv[c]), "snapshot event");
			wr(`TCM_OFS_COUNT, ~k_val);
			ticks(8);
			rd(`TCM_OFS_SNAPSHOT0 + 8'(4 * c), q);
			chk(q, k_val, "single capture");
			wr(`TCM_OFS_EVENT_FLAGS, 32'hFF);
			ticks(2);
		end
		$display("test snapshot done");
		// Pause holds the count, release lets it run
		wr(`TCM_OFS_PRE_LIMIT, 32'h1);
		wr(`TCM_OFS_RUN_CTRL, 32'h2);
		hold_req <= 1'b1;
		ticks(4);
		wr(`TCM_OFS_RUN_CTRL, 32'h1);
		ticks(20);
		rd(`TCM_OFS_COUNT, q);
		chk(q, 32'h0, "paused count");
		hold_req <= 1'b0;
		ticks(10);
		rd(`TCM_OFS_COUNT, q);
		chk(32'(q != 32'h0), 32'h1, "resumed count");
		rst_n <= 1'b0;
		ticks(3);
		rst_n <= 1'b1;
		rd(`TCM_OFS_RUN_CTRL, q);
		chk(q, 32'h0, "run after reset");
		$display("test pause done");
		conclude();
	end

	// Whole run needs about a thousand cycles; this margin only catches a hang
	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
endmodule

bind timer_capture_match_unit tcm_chk u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
	.snapshot_input(snapshot_input), .pause_in(pause_in),
	.compare_output(compare_output), .irq(irq));

`default_nettype wire
